// ==== hw/e1_tx_defs.svh ====
// timing and sizing constants for the line interface digital side
`ifndef E1_TX_DEFS_SVH
`define E1_TX_DEFS_SVH
`define E1_CLK_PERIOD_NS   10
`define E1_BIT_PERIOD_NS   488
`define E1_MARK_WIDTH_NS   244
`define E1_IDLE_LIMIT_NS   976
`define E1_MARK_CYC        (`E1_MARK_WIDTH_NS / `E1_CLK_PERIOD_NS)
`define E1_IDLE_CYC        (`E1_IDLE_LIMIT_NS / `E1_CLK_PERIOD_NS)
`define E1_CNT_W           8
`endif

// ==== hw/e1_tx_pkg.sv ====
// types shared by the line interface digital side
package e1_tx_pkg;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_NEAR_LOOP, MODE_FAR_LOOP, MODE_TEST} loop_mode_t;
   typedef enum logic {TX_IDLE, TX_MARK} tx_state_t;
   typedef struct packed {
      logic bit_clock;
      logic plus_rail;
      logic minus_rail;
      logic near_sel;
      logic far_sel;
      logic line_a;
      logic line_b;
   } pin_bus_t;
endpackage

// ==== hw/e1_lineside_tx_loop_ctrl.sv ====
// transmit entry, loopback routing and test mode of a single E1 line interface
`timescale 1ns/100ps
`include "e1_tx_defs.svh"
module e1_lineside_tx_loop_ctrl
   import e1_tx_pkg::*;
(
   input  wire logic clk,                 // 100 MHz system clock
   input  wire logic rst_n,               // async reset, active low
   input  wire logic transmit_bit_clock,  // transmit clock from terminal
   input  wire logic tx_plus_rail_in,     // positive rail data
   input  wire logic tx_minus_rail_in,    // negative rail data
   input  wire logic near_loop_select,    // local loopback select
   input  wire logic far_loop_select,     // remote loopback select
   input  wire logic line_in_a,           // received positive pulse
   input  wire logic line_in_b,           // received negative pulse
   output logic      line_out_a,          // positive line pulse
   output logic      line_out_a_oe,       // drive enable
   output logic      line_out_b,          // negative line pulse
   output logic      line_out_b_oe,       // drive enable
   output logic      rx_plus_rail_out,    // recovered positive pulse
   output logic      rx_plus_rail_out_oe, // drive enable
   output logic      rx_minus_rail_out,   // recovered negative pulse
   output logic      rx_minus_rail_out_oe // drive enable
);
   localparam logic [`E1_CNT_W-1:0] MARK_CYC = `E1_CNT_W'(`E1_MARK_CYC);
   localparam logic [`E1_CNT_W-1:0] IDLE_CYC = `E1_CNT_W'(`E1_IDLE_CYC);

   // single mark decode: a rail pair with both high carries no mark
   function automatic logic [1:0] mark_of(input logic p, input logic m);
      mark_of = {p & ~m, m & ~p};
   endfunction

   // pin synchronisers
   pin_bus_t pins_raw;
   pin_bus_t s1_r;
   pin_bus_t s2_r;
   pin_bus_t s3_r;
   pin_bus_t filt_r;
   pin_bus_t filt_nxt;

   assign pins_raw = '{transmit_bit_clock, tx_plus_rail_in, tx_minus_rail_in,
                       near_loop_select, far_loop_select, line_in_a, line_in_b};

   // accept a change once second and third stages agree
   always_comb
   begin
      filt_nxt = (s2_r ~^ s3_r) & s2_r | ~(s2_r ~^ s3_r) & filt_r;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         filt_r <= '0;
      end
      else
      begin
         s1_r   <= pins_raw;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // mode, clock activity and transmit pulse state
   loop_mode_t              mode_r;
   loop_mode_t              mode_nxt;
   logic                    clk_prev_r;
   logic                    clk_prev_nxt;
   logic [`E1_CNT_W-1:0]    idle_cnt_r;
   logic [`E1_CNT_W-1:0]    idle_cnt_nxt;
   tx_state_t               tx_state_r;
   tx_state_t               tx_state_nxt;
   logic [`E1_CNT_W-1:0]    mark_cnt_r;
   logic [`E1_CNT_W-1:0]    mark_cnt_nxt;
   logic                    mark_neg_r;
   logic                    mark_neg_nxt;
   logic                    clocked;
   logic                    fall;
   logic                    src_plus;
   logic                    src_minus;
   logic [1:0]              src_mark;
   logic [1:0]              rx_src;
   logic                    line_a_nxt;
   logic                    line_b_nxt;
   logic                    rx_plus_nxt;
   logic                    rx_minus_nxt;
   logic                    oe_nxt;
   logic                    oe_r;

   always_comb
   begin
      // each select acts only when high
      case ({filt_r.near_sel, filt_r.far_sel})
         2'b10:   mode_nxt = MODE_NEAR_LOOP;
         2'b01:   mode_nxt = MODE_FAR_LOOP;
         2'b11:   mode_nxt = MODE_TEST;
         default: mode_nxt = MODE_NORMAL;
      endcase
      clk_prev_nxt = filt_r.bit_clock;
      fall         = clk_prev_r & ~filt_r.bit_clock;
      // quiet clock for too long selects clockless path
      if (clk_prev_r != filt_r.bit_clock)
         idle_cnt_nxt = '0;
      else if (idle_cnt_r < IDLE_CYC)
         idle_cnt_nxt = idle_cnt_r + `E1_CNT_W'(1);
      else
         idle_cnt_nxt = idle_cnt_r;
      // far loop feeds recovered rails into transmit
      src_plus  = (mode_r == MODE_FAR_LOOP) ? rx_plus_rail_out : filt_r.plus_rail;
      src_minus = (mode_r == MODE_FAR_LOOP) ? rx_minus_rail_out : filt_r.minus_rail;
      src_mark  = mark_of(src_plus, src_minus);
      // looped receive pulses are RZ, so they bypass the clocked path
      clocked   = (idle_cnt_r < IDLE_CYC) && (mode_r != MODE_FAR_LOOP);
      tx_state_nxt = tx_state_r;
      mark_cnt_nxt = mark_cnt_r;
      mark_neg_nxt = mark_neg_r;
      case (tx_state_r)
         TX_IDLE:
         begin
            // falling clock edge samples both rails
            if (clocked && fall && (src_mark != 2'b00))
            begin
               tx_state_nxt = TX_MARK;
               mark_cnt_nxt = MARK_CYC;
               mark_neg_nxt = src_mark[0];
            end
         end
         TX_MARK:
         begin
            mark_cnt_nxt = mark_cnt_r - `E1_CNT_W'(1);
            if (mark_cnt_r == `E1_CNT_W'(1))
               tx_state_nxt = TX_IDLE;
         end
         default:
         begin
            tx_state_nxt = TX_IDLE;
            mark_cnt_nxt = '0;
         end
      endcase
      // polarity of the line pulse follows the rail
      if (clocked)
      begin
         line_a_nxt = (tx_state_nxt == TX_MARK) && !mark_neg_nxt;
         line_b_nxt = (tx_state_nxt == TX_MARK) && mark_neg_nxt;
      end
      else
      begin
         // rail pulses time the line pulse directly
         line_a_nxt = src_mark[1];
         line_b_nxt = src_mark[0];
      end
      // near loop returns the transmitted line to the receiver
      if (mode_r == MODE_NEAR_LOOP)
         rx_src = mark_of(line_out_a, line_out_b);
      else
         rx_src = mark_of(filt_r.line_a, filt_r.line_b);
      // one receive pulse per received polarity
      rx_plus_nxt  = rx_src[1];
      rx_minus_nxt = rx_src[0];
      oe_nxt = (mode_nxt != MODE_TEST);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r            <= MODE_NORMAL;
         clk_prev_r        <= 1'b0;
         idle_cnt_r        <= IDLE_CYC;
         tx_state_r        <= TX_IDLE;
         mark_cnt_r        <= '0;
         mark_neg_r        <= 1'b0;
         line_out_a        <= 1'b0;
         line_out_b        <= 1'b0;
         rx_plus_rail_out  <= 1'b0;
         rx_minus_rail_out <= 1'b0;
         oe_r              <= 1'b1;
      end
      else
      begin
         mode_r            <= mode_nxt;
         clk_prev_r        <= clk_prev_nxt;
         idle_cnt_r        <= idle_cnt_nxt;
         tx_state_r        <= tx_state_nxt;
         mark_cnt_r        <= mark_cnt_nxt;
         mark_neg_r        <= mark_neg_nxt;
         line_out_a        <= line_a_nxt;
         line_out_b        <= line_b_nxt;
         rx_plus_rail_out  <= rx_plus_nxt;
         rx_minus_rail_out <= rx_minus_nxt;
         oe_r              <= oe_nxt;
      end
   end

   assign line_out_a_oe        = oe_r;
   assign line_out_b_oe        = oe_r;
   assign rx_plus_rail_out_oe  = oe_r;
   assign rx_minus_rail_out_oe = oe_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence fall_plus_s;
      clocked && fall && (tx_state_r == TX_IDLE) && src_mark == 2'b10;
   endsequence
   sequence fall_minus_s;
      clocked && fall && (tx_state_r == TX_IDLE) && src_mark == 2'b01;
   endsequence
   sequence plus_mark_s;
      (line_out_a && !line_out_b)[*8];
   endsequence

   // sampled plus mark drives a positive pulse
   AST_CLOCKED_PLUS: assert property (fall_plus_s |=> plus_mark_s)
      else $error("plus mark not sent after falling clock");
   // sampled minus mark drives a negative pulse
   AST_CLOCKED_MINUS: assert property (fall_minus_s |=> line_out_b && !line_out_a)
      else $error("minus mark not sent after falling clock");
   AST_MARK_WIDTH: assert property ($rose(tx_state_r == TX_MARK) |-> (tx_state_r == TX_MARK)[*8]
                                    ##0 (mark_cnt_r == MARK_CYC - `E1_CNT_W'(7)))
      else $error("clocked mark width wrong");
   AST_ONE_POLARITY: assert property (!(line_out_a && line_out_b))
      else $error("both line outputs high");
   AST_CLOCKLESS: assert property (!clocked && src_mark == 2'b10 |=> line_out_a)
      else $error("clockless plus mark lost");
   // near loop returns the line output
   AST_NEAR_LOOP: assert property (mode_r == MODE_NEAR_LOOP && line_out_b && !line_out_a
                                   |=> rx_minus_rail_out)
      else $error("near loop did not return line");
   AST_FAR_LOOP: assert property (mode_r == MODE_FAR_LOOP && rx_plus_rail_out && !rx_minus_rail_out
                                  |=> line_out_a)
      else $error("far loop did not retransmit");
   // normal mode takes the line input
   AST_NORMAL_RX: assert property (mode_r == MODE_NORMAL && filt_r.line_a && !filt_r.line_b
                                   |=> rx_plus_rail_out)
      else $error("normal receive pulse missing");
   AST_TEST_HIZ: assert property (filt_r.near_sel && filt_r.far_sel |=> !line_out_a_oe && !rx_plus_rail_out_oe)
      else $error("outputs driven in test mode");
   AST_RX_ONE: assert property (!(rx_plus_rail_out && rx_minus_rail_out))
      else $error("both receive outputs high");
endmodule

// ==== test/e1_term_model.sv ====
// terminal equipment model driving transmit clock and rails
`timescale 1ns/100ps
module e1_term_model
(
   input  wire logic clk,        // system clock
   output logic      bit_clock,  // transmit clock to device
   output logic      plus_rail,  // positive rail
   output logic      minus_rail  // negative rail
);
   initial
   begin
      bit_clock  = 1'b0;
      plus_rail  = 1'b0;
      minus_rail = 1'b0;
   end
   // one nrz bit, clock then still
   task automatic send_clocked(input logic p, input logic n);
      @(posedge clk);
      bit_clock <= 1'b1;
      // rails launched after the rising edge, clock seen first
      repeat (3) @(posedge clk);
      plus_rail  <= p;
      minus_rail <= n;
      #32.5 bit_clock <= 1'b0;
      #62.5;
      @(posedge clk);
      plus_rail  <= 1'b0;
      minus_rail <= 1'b0;
   endtask
   task automatic rz(input logic p, input logic n, input int w);
      @(posedge clk);
      plus_rail  <= p;
      minus_rail <= n;
      repeat (w) @(posedge clk);
      plus_rail  <= 1'b0;
      minus_rail <= 1'b0;
   endtask
endmodule

// ==== test/e1_lineside_tx_loop_ctrl_tb.sv ====
// self-checking bench for transmit entry and loop control
`timescale 1ns/100ps
module e1_lineside_tx_loop_ctrl_tb;
   logic       clk, rst_n, bit_clock, plus_rail, minus_rail;
   logic       near_loop_select, far_loop_select, line_in_a, line_in_b;
   wire  [3:0] dout, oe;
   logic [7:0] w;
   int         failures, checked;

   e1_term_model i_term (.clk(clk), .bit_clock(bit_clock), .plus_rail(plus_rail), .minus_rail(minus_rail));
   e1_lineside_tx_loop_ctrl i_dut (.clk(clk), .rst_n(rst_n), .transmit_bit_clock(bit_clock),
      .tx_plus_rail_in(plus_rail), .tx_minus_rail_in(minus_rail), .near_loop_select(near_loop_select),
      .far_loop_select(far_loop_select), .line_in_a(line_in_a), .line_in_b(line_in_b),
      .line_out_a(dout[0]), .line_out_a_oe(oe[0]), .line_out_b(dout[1]), .line_out_b_oe(oe[1]),
      .rx_plus_rail_out(dout[2]), .rx_plus_rail_out_oe(oe[2]),
      .rx_minus_rail_out(dout[3]), .rx_minus_rail_out_oe(oe[3]));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // width in cycles of next pulse on one output, 0 if none
   task automatic pulse_w(input int idx, output logic [7:0] v);
      int n;
      v = 8'h00;
      n = 0;
      while (dout[idx] !== 1'b1 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      while (dout[idx] === 1'b1 && v < 8'hff)
      begin
         @(negedge clk);
         v++;
      end
   endtask
   task automatic line_pulse(input logic a, input logic b, input int n);
      @(posedge clk);
      line_in_a <= a;
      line_in_b <= b;
      repeat (n) @(posedge clk);
      line_in_a <= 1'b0;
      line_in_b <= 1'b0;
   endtask
   task automatic sel(input logic nr, input logic fr);
      @(posedge clk);
      near_loop_select <= nr;
      far_loop_select  <= fr;
      repeat (10) @(posedge clk);
   endtask

   task automatic t_clockless;
      fork i_term.rz(1'b1, 1'b0, 20); pulse_w(0, w); join
      chk("clockless plus", 8'h14, w);
      fork i_term.rz(1'b0, 1'b1, 20); pulse_w(1, w); join
      chk("clockless minus", 8'h14, w);
      $display("clockless test done");
   endtask
   task automatic t_clocked;
      for (int k = 0; k < 3; k++)
      begin
         fork i_term.send_clocked(k != 1, k != 0); pulse_w(k == 1, w); join
         chk("clocked mark", (k == 2) ? 8'h00 : 8'h18, w);
      end
      repeat (120) @(posedge clk);
      $display("clocked test done");
   endtask
   task automatic t_loops;
      fork line_pulse(1'b1, 1'b0, 20); pulse_w(2, w); join
      chk("rx plus", 8'h14, w);
      sel(1'b1, 1'b0);
      fork i_term.rz(1'b1, 1'b0, 20); pulse_w(2, w); join
      chk("near loop rx", 8'h14, w);
      fork i_term.rz(1'b0, 1'b1, 20); pulse_w(3, w); join
      chk("near loop rx minus", 8'h14, w);
      sel(1'b0, 1'b1);
      fork line_pulse(1'b0, 1'b1, 20); pulse_w(1, w); join
      chk("far loop tx", 8'h14, w);
      fork line_pulse(1'b1, 1'b0, 20); pulse_w(0, w); join
      chk("far loop tx plus", 8'h14, w);
      sel(1'b0, 1'b0);
      fork line_pulse(1'b0, 1'b1, 20); pulse_w(1, w); join
      chk("far loop off", 8'h00, w);
      $display("loop test done");
   endtask
   task automatic t_test_mode;
      sel(1'b1, 1'b1);
      chk("test mode oe", 8'h00, {4'h0, oe});
      sel(1'b0, 1'b0);
      chk("normal oe", 8'h0f, {4'h0, oe});
      $display("test mode test done");
   endtask

   task automatic summarize;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk);
      failures++;
      summarize();
   end

   initial
   begin
      failures = 0;
      checked = 0;
      rst_n = 1'b0;
      near_loop_select = 1'b0;
      far_loop_select = 1'b0;
      line_in_a = 1'b0;
      line_in_b = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_clockless();
      t_clocked();
      t_loops();
      t_test_mode();
      summarize();
   end
endmodule
